// ### hdl/afc_config_regs.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module afc_config_regs
    import afc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_B_I,
    // Register port
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    // Transfer engine side
    input  wire logic        XFER_START_I,
    input  wire logic [1:0]  XFER_MODE_I,
    output logic             XFER_BUSY_O,
    output logic             NV_WR_O,
    output logic             NV_RD_O,
    output logic      [10:0] NV_ADDR_O,
    output logic      [7:0]  NV_WDATA_O,
    input  wire logic [7:0]  NV_RDATA_I,
    input  wire logic        NV_ACK_I,
    // Converter activity
    input  wire logic        CONV_IDLE_I,
    // Gain controls, one-hot 1/2/4/8
    output logic      [3:0]  FRONT_GAIN_SEL_O,
    output logic      [3:0]  CONV_GAIN_SEL_O,
    // Bias levels in millivolts, zero means ground
    output logic      [10:0] FRONT_BIAS_MV_O,
    output logic      [10:0] AMP_A_BIAS_MV_O,
    output logic      [10:0] AMP_B_BIAS_MV_O,
    output logic             FRONT_BIAS_GND_O,
    output logic             AMP_A_BIAS_GND_O,
    output logic             AMP_B_BIAS_GND_O,
    // Switches and routing
    output logic             LADDER_TO_AMP_A_SWITCH_O,
    output logic             LADDER_TO_AMP_B_SWITCH_O,
    output logic             FRONT_AMP_TOPOLOGY_O,
    output logic             AMP_A_POS_INPUT_SEL_O,
    output logic             AMP_B_POS_INPUT_SEL_O,
    output logic             AUX_ANALOG_SWITCH_ON_O,
    output logic             NEG_INPUT_SOURCE_SEL_O,
    output logic             FRONT_AMP_PATH_ENABLE_O,
    output logic             LADDER_REFERENCE_SEL_O,
    output logic             CONVERTER_REFERENCE_SEL_O,
    // Power enables, one per block, then the full power-down flag
    output logic             PWR_BIAS_LADDER_O,
    output logic             PWR_AMP_B_O,
    output logic             PWR_AMP_A_O,
    output logic             PWR_OSC_O,
    output logic             PWR_FRONT_AMP_O,
    output logic             PWR_INT_REF_O,
    output logic             PWR_CONVERTER_O,
    output logic             FULL_POWER_DOWN_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    // Register map, one byte each
    //   0x0D  factory test byte, plain storage, never imaged
    //   0x0E  front gain [3:2], converter gain [1:0]
    //   0x0F  ladder switches [5:4], front bias code [3:0]
    //   0x10  amp_a bias code [7:5], amp_b bias code [4:0]
    //   0x11  topology, inputs, aux switch, routing, references
    //   0x12  keep-powered mask [7:1], bit 0 has no block
    // Bits without a field are masked on every write path,
    // so readback and decode never see stray ones.

    // Software visible bytes
    logic [7:0]   test_r;
    logic [7:0]   gain_r;
    logic [7:0]   conn0_r;
    logic [7:0]   conn1_r;
    logic [7:0]   conn2_r;
    logic [7:0]   mask_r;

    // Image sequencer state
    afc_state_t   state_r;
    logic [2:0]   idx_r;
    logic         req_r;

    // Load strobe and store data
    logic         ld_we;
    logic [7:0]   img_word;

    // Image word for the current index
    // Out-of-range index gives zero; the walk never reaches it
    always_comb begin
        case (idx_r)
            3'h0:    img_word = gain_r;
            3'h1:    img_word = conn0_r;
            3'h2:    img_word = conn1_r;
            3'h3:    img_word = conn2_r;
            3'h4:    img_word = mask_r;
            default: img_word = AFC_RST_VAL;
        endcase
    end

    // Load writes only on an acknowledged read cycle
    assign ld_we = (state_r == AFC_ST_LOAD) && NV_ACK_I;

    // Test byte kept plain; software is expected never to write it
    // Not guarded, so factory tooling can still reach it
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            test_r <= AFC_RST_VAL;
        end else if (WR_I && ADDR_I == AFC_OFS_TEST) begin
            test_r <= WDATA_I;
        end
    end

    // Load has priority: an image byte and a software write to the
    // same register in one cycle cannot both land, the image wins
    // Software writes; a load from the image lands over them
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            gain_r  <= AFC_RST_VAL;
            conn0_r <= AFC_RST_VAL;
            conn1_r <= AFC_RST_VAL;
            conn2_r <= AFC_RST_VAL;
            mask_r  <= AFC_RST_VAL;
        end else if (ld_we) begin
            case (idx_r)
                3'h0:    gain_r  <= NV_RDATA_I & AFC_GAIN_WMASK;
                3'h1:    conn0_r <= NV_RDATA_I & AFC_CONN0_WMASK;
                3'h2:    conn1_r <= NV_RDATA_I;
                3'h3:    conn2_r <= NV_RDATA_I;
                3'h4:    mask_r  <= NV_RDATA_I & AFC_MASK_WMASK;
                default: gain_r  <= gain_r;
            endcase
        end else if (WR_I) begin
            case (ADDR_I)
                AFC_OFS_GAIN:  gain_r  <= WDATA_I & AFC_GAIN_WMASK;
                AFC_OFS_CONN0: conn0_r <= WDATA_I & AFC_CONN0_WMASK;
                AFC_OFS_CONN1: conn1_r <= WDATA_I;
                AFC_OFS_CONN2: conn2_r <= WDATA_I;
                AFC_OFS_MASK:  mask_r  <= WDATA_I & AFC_MASK_WMASK;
                default:       mask_r  <= mask_r;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    // Cleared again after that cycle, so a stale byte never lingers
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            RDATA_O <= AFC_RST_VAL;
        end else if (RD_I) begin
            case (ADDR_I)
                AFC_OFS_TEST:  RDATA_O <= test_r;
                AFC_OFS_GAIN:  RDATA_O <= gain_r;
                AFC_OFS_CONN0: RDATA_O <= conn0_r;
                AFC_OFS_CONN1: RDATA_O <= conn1_r;
                AFC_OFS_CONN2: RDATA_O <= conn2_r;
                AFC_OFS_MASK:  RDATA_O <= mask_r;
                default:       RDATA_O <= AFC_RST_VAL;
            endcase
        end else begin
            RDATA_O <= AFC_RST_VAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bulk image transfer, one byte per acknowledged request

    // Image order: gain, conn0, conn1, conn2, mask.
    // A start while busy is ignored, so a second request cannot
    // restart the walk half way and tear the image.
    // The engine may acknowledge every cycle; the request stays up
    // across stalls and drops the cycle after the fifth acknowledge.
    // A write to any register but the test byte that meets a load acknowledge is lost, so
    // software should wait for busy to fall before writing.

    // Sequencer walks five locations; test byte has no image
    // Index resets in idle, so every walk starts at the base
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_r <= AFC_ST_IDLE;
            idx_r   <= 3'h0;
            req_r   <= 1'b0;
        end else begin
            case (state_r)
                AFC_ST_IDLE: begin
                    idx_r <= 3'h0;
                    req_r <= 1'b0;
                    if (XFER_START_I && XFER_MODE_I == AFC_XFER_LOAD) begin
                        state_r <= AFC_ST_LOAD;
                        req_r   <= 1'b1;
                    end else if (XFER_START_I && XFER_MODE_I == AFC_XFER_STORE) begin
                        state_r <= AFC_ST_STORE;
                        req_r   <= 1'b1;
                    end
                end
                AFC_ST_LOAD, AFC_ST_STORE: begin
                    if (NV_ACK_I) begin
                        if (idx_r == 3'(AFC_NV_COUNT - 1)) begin
                            state_r <= AFC_ST_IDLE;
                            req_r   <= 1'b0;
                        end else begin
                            idx_r <= idx_r + 3'h1;
                        end
                    end
                end
                default: begin
                    state_r <= AFC_ST_IDLE;
                    req_r   <= 1'b0;
                end
            endcase
        end
    end

    // Request lines held until acknowledged
    // Address is the image base plus the walk index; the store
    // data is the register that index names, valid with the request
    assign XFER_BUSY_O = (state_r != AFC_ST_IDLE);
    assign NV_RD_O     = req_r && (state_r == AFC_ST_LOAD);
    assign NV_WR_O     = req_r && (state_r == AFC_ST_STORE);
    assign NV_ADDR_O   = AFC_NV_GAIN + {8'h00, idx_r};
    assign NV_WDATA_O  = img_word;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded analog controls

    // All decode is combinational from the stored bytes, so each
    // control follows its register in the cycle after the write.
    // Bias values are nominal millivolts; a zero code ties the node
    // to ground and raises the matching ground flag instead.

    // Two-bit gain code to one-hot weight
    // Bit n of each select means a gain of two to the n
    assign FRONT_GAIN_SEL_O = 4'h1 << gain_r[AFC_GAIN_PRE_LSB +: 2];
    assign CONV_GAIN_SEL_O  = 4'h1 << gain_r[AFC_GAIN_ADC_LSB +: 2];

    // Extracted codes and amp_a level
    logic [3:0]  fcode;
    logic [2:0]  acode;
    logic [4:0]  bcode;
    logic [10:0] a_mv;

    // Bias code fields
    assign fcode = conn0_r[AFC_C0_FBIAS_LSB +: 4];
    assign acode = conn1_r[AFC_C1_ABIAS_LSB +: 3];
    assign bcode = conn1_r[AFC_C1_BBIAS_LSB +: 5];

    // Front bias: 0.3 V at code one, 100 mV a step
    // Code fifteen reaches 1.7 V, the top of the ladder
    assign FRONT_BIAS_MV_O  = (fcode == 4'h0) ? 11'h000
                            : 11'(200 + 100 * fcode);
    assign FRONT_BIAS_GND_O = (fcode == 4'h0);

    // Amp_a levels are irregular, so a table
    // Steps are not uniform, so no arithmetic form fits them
    always_comb begin
        case (acode)
            3'h0:    a_mv = 11'd0;
            3'h1:    a_mv = 11'd300;
            3'h2:    a_mv = 11'd500;
            3'h3:    a_mv = 11'd700;
            3'h4:    a_mv = 11'd1000;
            3'h5:    a_mv = 11'd1300;
            3'h6:    a_mv = 11'd1500;
            default: a_mv = 11'd1700;
        endcase
    end
    assign AMP_A_BIAS_MV_O  = a_mv;
    assign AMP_A_BIAS_GND_O = (acode == 3'h0);

    // Amp_b bias: 0.25 V at code one, 50 mV a step
    // Code thirty-one reaches 1.75 V
    assign AMP_B_BIAS_MV_O  = (bcode == 5'h00) ? 11'h000
                            : 11'(200 + 50 * bcode);
    assign AMP_B_BIAS_GND_O = (bcode == 5'h00);

    // Ladder switches follow their bits directly
    assign LADDER_TO_AMP_A_SWITCH_O  = conn0_r[AFC_C0_SWA_BIT];
    assign LADDER_TO_AMP_B_SWITCH_O  = conn0_r[AFC_C0_SWB_BIT];

    // Routing and reference selects, one bit each
    assign FRONT_AMP_TOPOLOGY_O      = conn2_r[AFC_C2_TOPO_BIT];
    assign AMP_A_POS_INPUT_SEL_O     = conn2_r[AFC_C2_AINSEL_BIT];
    assign AMP_B_POS_INPUT_SEL_O     = conn2_r[AFC_C2_BINSEL_BIT];
    assign AUX_ANALOG_SWITCH_ON_O    = conn2_r[AFC_C2_AUXSW_BIT];
    assign NEG_INPUT_SOURCE_SEL_O    = conn2_r[AFC_C2_NEGSRC_BIT];
    assign FRONT_AMP_PATH_ENABLE_O   = conn2_r[AFC_C2_PATH_BIT];
    assign LADDER_REFERENCE_SEL_O    = conn2_r[AFC_C2_LREF_BIT];
    assign CONVERTER_REFERENCE_SEL_O = conn2_r[AFC_C2_CREF_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Power gating; blocks stay up while the converter works

    // While a conversion runs every block is held on, whatever the
    // mask says; the mask only counts once the converter is idle.
    // High on a power line means the block is supplied.

    // Converter working
    logic busy_pw;
    assign busy_pw = !CONV_IDLE_I;

    assign PWR_BIAS_LADDER_O = busy_pw || mask_r[AFC_PW_LADDER_BIT];
    assign PWR_AMP_B_O       = busy_pw || mask_r[AFC_PW_AMPB_BIT];
    assign PWR_AMP_A_O       = busy_pw || mask_r[AFC_PW_AMPA_BIT];
    assign PWR_OSC_O         = busy_pw || mask_r[AFC_PW_OSC_BIT];
    assign PWR_FRONT_AMP_O   = busy_pw || mask_r[AFC_PW_FRONT_BIT];
    assign PWR_INT_REF_O     = busy_pw || mask_r[AFC_PW_IREF_BIT];
    assign PWR_CONVERTER_O   = busy_pw || mask_r[AFC_PW_CONV_BIT];

    // Only digital logic survives an all-zero mask when idle
    // Mask bit 0 is never stored, so it cannot hold off this state
    assign FULL_POWER_DOWN_O = CONV_IDLE_I && (mask_r == AFC_RST_VAL);

    // Limitations: no interlock between software writes and a load,
    // and no check of the image contents; a loaded byte goes in as
    // read, with only the unassigned bits cleared.

endmodule

`default_nettype wire

// ### hdl/afc_pkg.sv
`default_nettype none
package afc_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] AFC_OFS_TEST   = 8'h0D;
    localparam logic [7:0] AFC_OFS_GAIN   = 8'h0E;
    localparam logic [7:0] AFC_OFS_CONN0  = 8'h0F;
    localparam logic [7:0] AFC_OFS_CONN1  = 8'h10;
    localparam logic [7:0] AFC_OFS_CONN2  = 8'h11;
    localparam logic [7:0] AFC_OFS_MASK   = 8'h12;

    // Nonvolatile image locations
    localparam logic [10:0] AFC_NV_GAIN   = 11'h000;
    localparam logic [10:0] AFC_NV_CONN0  = 11'h001;
    localparam logic [10:0] AFC_NV_CONN1  = 11'h002;
    localparam logic [10:0] AFC_NV_CONN2  = 11'h003;
    localparam logic [10:0] AFC_NV_MASK   = 11'h004;
    localparam int          AFC_NV_COUNT  = 5;

    // Writable bit masks
    localparam logic [7:0] AFC_GAIN_WMASK  = 8'h0F;
    localparam logic [7:0] AFC_CONN0_WMASK = 8'h3F;
    localparam logic [7:0] AFC_MASK_WMASK  = 8'hFE;

    // Field positions
    localparam int AFC_GAIN_PRE_LSB   = 2;
    localparam int AFC_GAIN_ADC_LSB   = 0;
    localparam int AFC_C0_SWA_BIT     = 5;
    localparam int AFC_C0_SWB_BIT     = 4;
    localparam int AFC_C0_FBIAS_LSB   = 0;
    localparam int AFC_C1_ABIAS_LSB   = 5;
    localparam int AFC_C1_BBIAS_LSB   = 0;
    localparam int AFC_C2_TOPO_BIT    = 7;
    localparam int AFC_C2_AINSEL_BIT  = 6;
    localparam int AFC_C2_BINSEL_BIT  = 5;
    localparam int AFC_C2_AUXSW_BIT   = 4;
    localparam int AFC_C2_NEGSRC_BIT  = 3;
    localparam int AFC_C2_PATH_BIT    = 2;
    localparam int AFC_C2_LREF_BIT    = 1;
    localparam int AFC_C2_CREF_BIT    = 0;
    localparam int AFC_PW_LADDER_BIT  = 7;
    localparam int AFC_PW_AMPB_BIT    = 6;
    localparam int AFC_PW_AMPA_BIT    = 5;
    localparam int AFC_PW_OSC_BIT     = 4;
    localparam int AFC_PW_FRONT_BIT   = 3;
    localparam int AFC_PW_IREF_BIT    = 2;
    localparam int AFC_PW_CONV_BIT    = 1;

    // Reset values
    localparam logic [7:0] AFC_RST_VAL = 8'h00;

    // Transfer engine commands
    localparam logic [1:0] AFC_XFER_LOAD  = 2'h2;
    localparam logic [1:0] AFC_XFER_STORE = 2'h3;

    // Transfer sequencer states
    typedef enum logic [2:0] {
        AFC_ST_IDLE  = 3'b001,
        AFC_ST_LOAD  = 3'b010,
        AFC_ST_STORE = 3'b100
    } afc_state_t;

endpackage

`default_nettype wire

// ### sim/afc_config_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module afc_config_regs_asserts
    import afc_pkg::*;
(
    // Clock, reset and register port
    input wire logic        CLOCK_I,
    input wire logic        RST_B_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [7:0]  RDATA_O,
    // Transfer engine
    input wire logic        XFER_START_I,
    input wire logic [1:0]  XFER_MODE_I,
    input wire logic        XFER_BUSY_O,
    input wire logic        NV_RD_O,
    input wire logic [10:0] NV_ADDR_O,
    // Decoded controls
    input wire logic        CONV_IDLE_I,
    input wire logic [3:0]  FRONT_GAIN_SEL_O,
    input wire logic [3:0]  CONV_GAIN_SEL_O,
    input wire logic        AMP_B_BIAS_GND_O,
    input wire logic        FRONT_AMP_TOPOLOGY_O,
    input wire logic        CONVERTER_REFERENCE_SEL_O,
    input wire logic        PWR_BIAS_LADDER_O,
    input wire logic        PWR_CONVERTER_O,
    input wire logic        FULL_POWER_DOWN_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    ////////////////////////////////////////////////////////////////////////
    // Writes count only while no load can overwrite them
    wire logic  sw_wr = WR_I && !XFER_BUSY_O;
    logic [7:0] wd_q;
    // Last write data, for fields checked one cycle later
    always_ff @(posedge CLOCK_I) begin
        wd_q <= WDATA_I;
    end
    ////////////////////////////////////////////////////////////////////////
    a_gain_reserved_zero: assert property (RD_I && ADDR_I == AFC_OFS_GAIN |=>
        RDATA_O[7:4] == 4'h0) else $error("gain reserved bits not zero");
    a_gain_decode_hot: assert property (sw_wr && ADDR_I == AFC_OFS_GAIN |=>
        FRONT_GAIN_SEL_O == (4'h1 << wd_q[3:2]) && CONV_GAIN_SEL_O == (4'h1 << wd_q[1:0]))
        else $error("gain decode wrong");
    a_routing_bits: assert property (sw_wr && ADDR_I == AFC_OFS_CONN2 |=>
        FRONT_AMP_TOPOLOGY_O == wd_q[7] && CONVERTER_REFERENCE_SEL_O == wd_q[0])
        else $error("routing bits wrong");
    a_amp_b_ground: assert property (sw_wr && ADDR_I == AFC_OFS_CONN1 |=>
        AMP_B_BIAS_GND_O == (wd_q[4:0] == 5'h00)) else $error("amp_b ground wrong");
    a_active_powered: assert property (!CONV_IDLE_I |-> PWR_BIAS_LADDER_O &&
        PWR_CONVERTER_O && !FULL_POWER_DOWN_O) else $error("block off while active");
    a_full_down_idle: assert property (FULL_POWER_DOWN_O |-> CONV_IDLE_I &&
        !PWR_BIAS_LADDER_O && !PWR_CONVERTER_O) else $error("full power down wrong");
    a_load_start: assert property (!XFER_BUSY_O && XFER_START_I &&
        XFER_MODE_I == AFC_XFER_LOAD |=> XFER_BUSY_O && NV_RD_O && NV_ADDR_O == 11'h000)
        else $error("load did not start at image base");
    a_image_range: assert property (NV_RD_O |-> NV_ADDR_O <= AFC_NV_MASK)
        else $error("image address out of range");
endmodule
bind afc_config_regs afc_config_regs_asserts u_afc_config_regs_asserts (
    .CLOCK_I, .RST_B_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .XFER_START_I,
    .XFER_MODE_I, .XFER_BUSY_O, .NV_RD_O, .NV_ADDR_O, .CONV_IDLE_I, .FRONT_GAIN_SEL_O,
    .CONV_GAIN_SEL_O, .AMP_B_BIAS_GND_O, .FRONT_AMP_TOPOLOGY_O, .CONVERTER_REFERENCE_SEL_O,
    .PWR_BIAS_LADDER_O, .PWR_CONVERTER_O, .FULL_POWER_DOWN_O
);
`default_nettype wire

// ### sim/afc_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module afc_config_regs_tb_top;
    import afc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        start = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  nv_rdata = 8'h00;
    logic        ack = 1'b0;
    logic        idle = 1'b0;
    wire logic [7:0]  rdata, nv_wdata;
    wire logic [3:0]  fgain, cgain;
    wire logic [10:0] nv_addr, fmv, amv, bmv;
    wire logic [9:0]  sw;
    wire logic [6:0]  pwr;
    wire logic        busy, nv_wr, nv_rd, fgnd, agnd, bgnd, fpd;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [31:0] seed = 32'hC091;
    logic [7:0]  exp_q[$];
    logic        rd_seen = 1'b0;
    logic [7:0]  shadow[6];
    // Index order matches the image order; test byte last
    logic [7:0]  ofs[6] = '{AFC_OFS_GAIN, AFC_OFS_CONN0, AFC_OFS_CONN1, AFC_OFS_CONN2,
                            AFC_OFS_MASK, AFC_OFS_TEST};
    logic [7:0]  wm[6] = '{8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFE, 8'hFF};
    logic [10:0] a_mv[8] = '{11'h000, 11'h12C, 11'h1F4, 11'h2BC, 11'h3E8, 11'h514,
                             11'h5DC, 11'h6A4};

    afc_config_regs u_afc_config_regs (
        .CLOCK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .XFER_START_I(start), .XFER_MODE_I(mode),
        .XFER_BUSY_O(busy), .NV_WR_O(nv_wr), .NV_RD_O(nv_rd), .NV_ADDR_O(nv_addr),
        .NV_WDATA_O(nv_wdata), .NV_RDATA_I(nv_rdata), .NV_ACK_I(ack), .CONV_IDLE_I(idle),
        .FRONT_GAIN_SEL_O(fgain), .CONV_GAIN_SEL_O(cgain), .FRONT_BIAS_MV_O(fmv),
        .AMP_A_BIAS_MV_O(amv), .AMP_B_BIAS_MV_O(bmv), .FRONT_BIAS_GND_O(fgnd),
        .AMP_A_BIAS_GND_O(agnd), .AMP_B_BIAS_GND_O(bgnd),
        .LADDER_TO_AMP_A_SWITCH_O(sw[9]), .LADDER_TO_AMP_B_SWITCH_O(sw[8]),
        .FRONT_AMP_TOPOLOGY_O(sw[7]), .AMP_A_POS_INPUT_SEL_O(sw[6]),
        .AMP_B_POS_INPUT_SEL_O(sw[5]), .AUX_ANALOG_SWITCH_ON_O(sw[4]),
        .NEG_INPUT_SOURCE_SEL_O(sw[3]), .FRONT_AMP_PATH_ENABLE_O(sw[2]),
        .LADDER_REFERENCE_SEL_O(sw[1]), .CONVERTER_REFERENCE_SEL_O(sw[0]),
        .PWR_BIAS_LADDER_O(pwr[6]), .PWR_AMP_B_O(pwr[5]), .PWR_AMP_A_O(pwr[4]),
        .PWR_OSC_O(pwr[3]), .PWR_FRONT_AMP_O(pwr[2]), .PWR_INT_REF_O(pwr[1]),
        .PWR_CONVERTER_O(pwr[0]), .FULL_POWER_DOWN_O(fpd)
    );
    ////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz
    always #2.5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Gap cycle between strobes so no strobe is driven twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic wr_idx(input int i, input logic [7:0] d);
        wr_reg(ofs[i], d);
        shadow[i] = d & wm[i];
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Unmapped offset last; it must read zero
    task automatic read_all;
        for (int i = 0; i < 6; i++) rd_reg(ofs[i], shadow[i]);
        rd_reg(8'h20, 8'h00);
    endtask

    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) shadow[i] = 8'h00;
    endtask

    task automatic kick(input logic [1:0] m);
        @(posedge clk);
        start <= 1'b1;
        mode <= m;
        @(posedge clk);
        start <= 1'b0;
        #1;
    endtask

    // Image side answers after one to four cycles: a random stall of zero to three, then one more
    task automatic xfer(input logic [1:0] m);
        logic [7:0] v;
        kick(m);
        for (int i = 0; i < AFC_NV_COUNT; i++) begin
            seed = xs(seed);
            v = seed[15:8];
            repeat (seed[1:0]) @(posedge clk);
            #1;
            chk({10'h0, (m == AFC_XFER_LOAD) ? nv_rd : nv_wr}, 11'h001);
            chk(nv_addr, 11'(i));
            if (m == AFC_XFER_STORE) chk({3'h0, nv_wdata}, {3'h0, shadow[i]});
            @(posedge clk);
            ack <= 1'b1;
            nv_rdata <= v;
            @(posedge clk);
            ack <= 1'b0;
            if (m == AFC_XFER_LOAD) shadow[i] = v & wm[i];
        end
        #1;
        chk({10'h0, busy}, 11'h000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read results are matched in order; timeout ends the run
    always @(posedge clk) begin
        if (rd_seen) chk({3'h0, rdata}, {3'h0, exp_q.pop_front()});
        rd_seen <= rd;
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            wrap_up();
        end
    end

    // Main sequence; the test byte is only ever read
    initial begin
        logic [7:0] m;
        do_reset();
        read_all();
        wr_reg(8'h20, 8'hFF);
        for (int k = 0; k < 64; k++) begin
            seed = xs(seed);
            wr_idx(0, {seed[7:4], k[3:0]});
            wr_idx(1, {seed[7:6], k[5:0]});
            wr_idx(2, {k[2:0], k[4:0]});
            wr_idx(3, seed[15:8]);
            chk({7'h0, fgain}, 11'h001 << k[3:2]);
            chk({7'h0, cgain}, 11'h001 << k[1:0]);
            chk(fmv, (k[3:0] == 4'h0) ? 11'h000 : 11'h0C8 + 11'h064 * k[3:0]);
            chk(amv, a_mv[k[2:0]]);
            chk(bmv, (k[4:0] == 5'h00) ? 11'h000 : 11'h0C8 + 11'h032 * k[4:0]);
            chk({8'h0, fgnd, agnd, bgnd}, {8'h0, k[3:0] == 0, k[2:0] == 0, k[4:0] == 0});
            chk({1'b0, sw}, {1'b0, shadow[1][5:4], shadow[3]});
            if (k % 8 == 0) read_all();
        end
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            m = (k < 2) ? 8'(k) : seed[7:0];
            @(posedge clk);
            idle <= (k < 2) | seed[8];
            wr_idx(4, m);
            chk({4'h0, pwr}, {4'h0, {7{!idle}} | shadow[4][7:1]});
            chk({10'h0, fpd}, {10'h0, idle && shadow[4] == 8'h00});
        end
        for (int k = 0; k < 2; k++) begin
            kick(2'(k));
            chk({10'h0, busy}, 11'h000);
        end
        xfer(AFC_XFER_LOAD);
        read_all();
        xfer(AFC_XFER_STORE);
        do_reset();
        read_all();
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
